//--- verilog/dpa_port_host.sv
// Host controller that drives one port of the dual-port RAM through its pins.
`timescale 1ns/10ps

module dpa_port_host
  import dpa_pkg::*;
#(
  parameter int STROBE_DELAY = 0  // Extra strobe delay cycles for slave ports.
) (
  input  wire logic              sys_clk,     // System clock, 200 MHz.
  input  wire logic              reset_n,     // Asynchronous reset, low.
  input  wire logic              reqValid,    // Start one access.
  output logic                   reqReady,    // Host idle, request taken.
  input  wire logic              reqWrite,    // One for write, zero for read.
  input  wire logic [10:0]       reqAddr,     // Byte address.
  input  wire logic [7:0]        reqWdata,    // Write data.
  output logic                   rspValid,    // Access finished, one cycle.
  output logic [7:0]             rspRdata,    // Read data.
  output logic                   irqPending,  // Own interrupt, synchronised.
  output logic [10:0]            portAddr,    // Address pins.
  input  wire logic [7:0]        portDataIn,  // Data pins, sampled.
  output logic [7:0]             portDataOut, // Data pins, driven.
  output logic                   portDataOe,  // High while host drives data.
  output logic                   chipSelN,    // Chip select, low active.
  output logic                   writeN,      // Write strobe, low active.
  output logic                   outEnN,      // Output enable, low active.
  input  wire logic              busyN,       // Busy from master, low.
  input  wire logic              intN         // Interrupt flag, low.
);

  ////////////////////////////////////////////////////////////////////////////
  // State register and its next value.
  dpa_host_t host_r;
  dpa_host_t host_nxt;

  localparam logic [3:0] WR_CYC   = 4'(MIN_WRITE_PULSE_CYC);
  localparam logic [3:0] RD_CYC   = 4'(READ_DATA_CYC);
  localparam logic [3:0] SLV_CYC  = 4'(MATCH_TO_BUSY_CYC + STROBE_DELAY);

  // Busy is low after the second synchroniser stage.
  // The host only listens to busy, so it never fights a master over it.
  logic busySeen;
  assign busySeen = ~host_r.busySync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the access sequencer.
  always_comb begin
    host_nxt = host_r;
    host_nxt.done = 1'b0;
    // Busy and interrupt pins pass two flip-flops before use.
    host_nxt.busySync = {host_r.busySync[0], busyN};
    host_nxt.intSync  = {host_r.intSync[0], intN};
    case (host_r.state)
      ST_IDLE: begin
        if (reqValid) begin
          host_nxt.isWrite       = reqWrite;
          host_nxt.retried       = 1'b0;
          host_nxt.pins.addr     = reqAddr;
          host_nxt.pins.dataOut  = reqWdata;
          host_nxt.pins.chipSelN = 1'b0;
          host_nxt.pins.outEnN   = reqWrite;
          host_nxt.pins.dataOe   = 1'b0;
          // Slaves see the strobe only after arbitration settles.
          host_nxt.cnt   = (STROBE_DELAY > 0) ? SLV_CYC : 4'h1;
          host_nxt.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Chip select leads the strobe so read data is not tristated.
        if (host_r.cnt <= 4'h1) begin
          host_nxt.pins.writeN = ~host_r.isWrite;
          host_nxt.pins.dataOe = host_r.isWrite;
          host_nxt.cnt   = host_r.isWrite ? WR_CYC : RD_CYC;
          host_nxt.state = ST_STROBE;
        end else begin
          host_nxt.cnt = host_r.cnt - 4'h1;
        end
      end
      ST_STROBE: begin
        if (busySeen) begin
          // Busy means not ready: hold the strobe and wait.
          host_nxt.retried = 1'b1;
          host_nxt.state   = ST_WAIT;
        end else if (host_r.cnt <= 4'h1) begin
          host_nxt.state = ST_DONE;
        end else begin
          host_nxt.cnt = host_r.cnt - 4'h1;
        end
      end
      ST_WAIT: begin
        if (!busySeen) begin
          // Extend by a full pulse so the retried write overwrites.
          host_nxt.cnt   = host_r.isWrite ? WR_CYC : RD_CYC;
          host_nxt.state = ST_EXTEND;
        end
      end
      ST_EXTEND: begin
        if (busySeen) begin
          host_nxt.state = ST_WAIT;
        end else if (host_r.cnt <= 4'h1) begin
          host_nxt.state = ST_DONE;
        end else begin
          host_nxt.cnt = host_r.cnt - 4'h1;
        end
      end
      ST_DONE: begin
        // Sample flow-through data, then drop strobe and chip select in the same cycle.
        host_nxt.rdData        = portDataIn;
        host_nxt.pins.writeN   = 1'b1;
        host_nxt.pins.dataOe   = 1'b0;
        host_nxt.pins.chipSelN = 1'b1;
        host_nxt.pins.outEnN   = 1'b1;
        host_nxt.done          = 1'b1;
        host_nxt.state         = ST_IDLE;
      end
      default: begin
        host_nxt.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State flip-flops with constant reset values.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_r               <= '0;
      host_r.state         <= ST_IDLE;
      host_r.cnt           <= DPA_CNT_RST;
      host_r.pins.chipSelN <= 1'b1;
      host_r.pins.writeN   <= 1'b1;
      host_r.pins.outEnN   <= 1'b1;
      host_r.busySync      <= DPA_SYNC_RST;
      host_r.intSync       <= DPA_SYNC_RST;
    end else begin
      host_r <= host_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output assignments.
  assign reqReady    = (host_r.state == ST_IDLE);
  assign rspValid    = host_r.done;
  assign rspRdata    = host_r.rdData;
  assign irqPending  = ~host_r.intSync[1];
  assign portAddr    = host_r.pins.addr;
  assign portDataOut = host_r.pins.dataOut;
  assign portDataOe  = host_r.pins.dataOe;
  assign chipSelN    = host_r.pins.chipSelN;
  assign writeN      = host_r.pins.writeN;
  assign outEnN      = host_r.pins.outEnN;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pin sequence.

  // A write strobe never appears without chip select.
  property p_strobe_cs;
    @(posedge sys_clk) disable iff (!reset_n)
      !writeN |-> !chipSelN;
  endproperty
  a_strobe_cs: assert property (p_strobe_cs)
    else $error("Write strobe low without chip select.");

  // Chip select is already low the cycle before the strobe falls.
  property p_cs_first;
    @(posedge sys_clk) disable iff (!reset_n)
      $fell(writeN) |-> $past(!chipSelN);
  endproperty
  a_cs_first: assert property (p_cs_first)
    else $error("Chip select did not precede write strobe.");

  // While busy is seen the access is held, never finished.
  property p_busy_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      (host_r.state == ST_WAIT && busySeen) |=> !rspValid && !chipSelN;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Access ended while busy was active.");

  // After busy release a write keeps its strobe a full pulse.
  property p_extend;
    @(posedge sys_clk) disable iff (!reset_n)
      (host_r.state == ST_WAIT && !busySeen && host_r.isWrite)
        |=> (!writeN)[*3];
  endproperty
  a_extend: assert property (p_extend)
    else $error("Write not extended after busy release.");

  // A busy seen during the strobe parks the access in the wait state.
  property p_busy_wait;
    @(posedge sys_clk) disable iff (!reset_n)
      (host_r.state == ST_STROBE && busySeen)
        |=> (host_r.state == ST_WAIT && host_r.retried);
  endproperty
  a_busy_wait: assert property (p_busy_wait)
    else $error("Busy during the strobe did not stop the access.");

  // Outputs are enabled only in a selected read with the strobe high.
  property p_read_oe;
    @(posedge sys_clk) disable iff (!reset_n)
      !outEnN |-> (writeN && !chipSelN && !portDataOe);
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("Output enable low outside a selected read.");

  // A slave-bank port has chip select low SLV_CYC cycles before its write strobe falls.
  property p_slave_delay;
    @(posedge sys_clk) disable iff (!reset_n)
      (STROBE_DELAY > 0 && $fell(writeN)) |-> $past(!chipSelN, SLV_CYC);
  endproperty
  a_slave_delay: assert property (p_slave_delay)
    else $error("Slave write strobe came before arbitration settled.");

endmodule

//--- verilog/dpa_pkg.sv
// Package with constants and carrier types for the dual-port RAM port host.
package dpa_pkg;

  // Memory geometry and mailbox locations.
  localparam int          DPA_ADDR_W    = 11;
  localparam int          DPA_DATA_W    = 8;
  localparam logic [10:0] DPA_MBOX_RIGHT = 11'h7FF;
  localparam logic [10:0] DPA_MBOX_LEFT  = 11'h7FE;

  // Clock period and device timing in nanoseconds.
  localparam int CLK_PERIOD_NS             = 5;
  localparam int PRIORITY_SETUP_INTERVAL_NS = 5;
  localparam int MATCH_TO_BUSY_DELAY_NS     = 15;
  localparam int MIN_WRITE_PULSE_NS         = 12;
  localparam int WRITE_PULSE_TO_DATA_DELAY_NS = 30;

  // Least times round up to whole cycles, never below one.
  localparam int MATCH_TO_BUSY_CYC =
    (MATCH_TO_BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_WRITE_PULSE_CYC =
    (MIN_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_DATA_CYC =
    (WRITE_PULSE_TO_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the host's cycle counter and reset values.
  localparam int         DPA_CNT_W    = 4;
  localparam logic [3:0] DPA_CNT_RST  = 4'h0;
  localparam logic [1:0] DPA_SYNC_RST = 2'h3;

  // Host sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_WAIT,
    ST_EXTEND,
    ST_DONE
  } dpa_state_t;

  // Pins driven toward one device port.
  typedef struct packed {
    logic [10:0] addr;
    logic [7:0]  dataOut;
    logic        dataOe;
    logic        chipSelN;
    logic        writeN;
    logic        outEnN;
  } dpa_pins_t;

  // Whole state of the host.
  typedef struct packed {
    dpa_state_t  state;
    logic [3:0]  cnt;
    logic        isWrite;
    logic        retried;
    logic [7:0]  rdData;
    logic        done;
    dpa_pins_t   pins;
    logic [1:0]  busySync;
    logic [1:0]  intSync;
  } dpa_host_t;

endpackage

//--- verification/dpa_ram_model.sv
// Behavioural model of the dual-port RAM device facing two port hosts.
`timescale 1ns/10ps
module dpa_ram_model
  import dpa_pkg::*;
(
  input  wire logic            sys_clk, // Sampling clock of the model.
  input  wire dpa_pins_t [1:0] pins,    // Pins of both hosts, 0 is left.
  output logic [1:0][7:0]      dataIn,  // Data wire level per port.
  output logic [1:0]           busyN,   // Busy per port, low active.
  output logic [1:0]           intN     // Interrupt per port, low active.
);
  logic [7:0]      mem [0:2047]; // Byte store.
  logic [1:0][7:0] last_r  = '0;
  logic [1:0][3:0] age_r   = '0;
  logic [1:0]      intN_r  = 2'h3;
  logic [1:0]      sel;
  logic [1:0]      rd;
  logic            match;
  logic            win;
  logic            own_r   = 1'b0;
  logic            owned_r = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Select lines and the address match that starts arbitration.
  assign sel   = ~{pins[1].chipSelN, pins[0].chipSelN};
  assign match = &sel && pins[0].addr == pins[1].addr;
  assign intN  = intN_r;

  // The longer selected port wins; a tie goes to the left port.
  always_comb begin
    win = owned_r ? own_r : age_r[1] > age_r[0];
    for (int i = 0; i < 2; i++) begin
      rd[i]     = sel[i] && !pins[i].outEnN && pins[i].writeN;
      busyN[i]  = !(match && win != 1'(i));
      dataIn[i] = pins[i].dataOe ? pins[i].dataOut :
                  rd[i] ? mem[pins[i].addr] : ~last_r[i];
    end
  end

  // Writes, mailbox flags and select ages on each clock.
  always @(posedge sys_clk) begin
    owned_r <= match;
    own_r   <= win;
    for (int i = 0; i < 2; i++) begin
      age_r[i]  <= sel[i] ? age_r[i] + 4'(age_r[i] != 4'hF) : 4'h0;
      last_r[i] <= dataIn[i];
      if (sel[i] && !pins[i].writeN
          && busyN[i]) begin
        mem[pins[i].addr] <= pins[i].dataOut;
        if (pins[i].addr == (i ? DPA_MBOX_LEFT : DPA_MBOX_RIGHT)) begin
          intN_r[1-i] <= 1'b0;
        end
      end
      if (rd[i] && pins[i].addr == (i ? DPA_MBOX_RIGHT : DPA_MBOX_LEFT)) begin
        intN_r[i] <= 1'b1;
      end
    end
  end
endmodule

//--- verification/tb_top.sv
// Testbench with two port hosts sharing one dual-port RAM model.
`timescale 1ns/10ps
module tb_top;
  import dpa_pkg::*;
  logic            sys_clk  = 1'b0;
  logic            reset_n  = 1'b0;
  logic [1:0]      reqValid = 2'h0;
  logic [1:0]      reqWrite = 2'h0;
  logic [1:0][10:0] reqAddr = '0;
  logic [1:0][7:0] reqWdata = '0;
  wire  [1:0]       reqReady, rspValid, irqPending, portDataOe;
  wire  [1:0]       chipSelN, writeN, outEnN, busyN, intN;
  logic [1:0]       sawBusy = 2'h0;
  logic             clrBusy = 1'b0;
  wire  [1:0][10:0] portAddr;
  wire  [1:0][7:0]  rspRdata, portDataIn, portDataOut;
  wire  dpa_pins_t [1:0] pins;
  int               n_fail = 0;
  int               checked = 0;
  int               lastWait = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a record of which port was told busy since the last clrBusy.
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) sawBusy <= clrBusy ? 2'h0 : sawBusy | ~busyN;

  // One host per port; the right one is a slave-bank port with a late strobe.
  for (genvar i = 0; i < 2; i++) begin : g_port
    assign pins[i] = {portAddr[i], portDataOut[i], portDataOe[i],
                      chipSelN[i], writeN[i], outEnN[i]};
    dpa_port_host #(.STROBE_DELAY(i)) dpa_port_host_inst (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .reqValid(reqValid[i]), .reqReady(reqReady[i]),
      .reqWrite(reqWrite[i]), .reqAddr(reqAddr[i]), .reqWdata(reqWdata[i]),
      .rspValid(rspValid[i]), .rspRdata(rspRdata[i]),
      .irqPending(irqPending[i]), .portAddr(portAddr[i]),
      .portDataIn(portDataIn[i]), .portDataOut(portDataOut[i]),
      .portDataOe(portDataOe[i]), .chipSelN(chipSelN[i]),
      .writeN(writeN[i]), .outEnN(outEnN[i]), .busyN(busyN[i]),
      .intN(intN[i]));
  end
  dpa_ram_model dpa_ram_model_inst (.sys_clk(sys_clk), .pins(pins),
    .dataIn(portDataIn), .busyN(busyN), .intN(intN));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, close the run, and perform one access on one port.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic access(input int p, input logic w, input logic [10:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    int k;
    @(negedge sys_clk);
    reqValid[p] = 1'b1;
    reqWrite[p] = w;
    reqAddr[p]  = a;
    reqWdata[p] = d;
    @(negedge sys_clk);
    reqValid[p] = 1'b0;
    for (k = 0; k < 200 && rspValid[p] !== 1'b1; k++) @(negedge sys_clk);
    if (k == 200) begin
      n_fail++;
      final_report();
    end
    q = rspRdata[p];
    lastWait = k;
  endtask

  // Plain write on the left, read back through the right.
  task automatic t_plain;
    logic [7:0] q;
    access(0, 1'b1, 11'h000, 8'h5A, q);
    check(8'(lastWait), 8'(2 + MIN_WRITE_PULSE_CYC));
    access(0, 1'b1, 11'h7FD, 8'hC3, q);
    access(1, 1'b0, 11'h000, 8'h00, q);
    check(q, 8'h5A);
    check(8'(lastWait),
          8'(2 + MATCH_TO_BUSY_CYC + READ_DATA_CYC));
    access(1, 1'b0, 11'h7FD, 8'h00, q);
    check(q, 8'hC3);
    check({6'h00, irqPending}, 8'h00);
    $display("t_plain done");
  endtask

  // Each port posts to the other's mailbox, the owner reads it.
  task automatic t_mailbox;
    logic [7:0] q;
    for (int p = 0; p < 2; p++) begin
      access(p, 1'b1, p ? DPA_MBOX_LEFT : DPA_MBOX_RIGHT, 8'h81 + 8'(p), q);
      repeat (4) @(negedge sys_clk);
      check({6'h00, irqPending}, p ? 8'h01 : 8'h02);
      access(1 - p, 1'b0, p ? DPA_MBOX_LEFT : DPA_MBOX_RIGHT, 8'h00, q);
      check(q, 8'h81 + 8'(p));
      repeat (4) @(negedge sys_clk);
      check({6'h00, irqPending}, 8'h00);
    end
    $display("t_mailbox done");
  endtask

  // Left reads first, right writes one cycle later and must wait.
  task automatic t_contend_write;
    logic [7:0] q0, q1;
    time        t0, t1;
    access(0, 1'b1, 11'h123, 8'hAA, q0);
    clrBusy = 1'b1;
    @(negedge sys_clk);
    clrBusy = 1'b0;
    fork
      begin access(0, 1'b0, 11'h123, 8'h00, q0); t0 = $time; end
      begin @(negedge sys_clk); access(1, 1'b1, 11'h123, 8'h55, q1);
        t1 = $time; end
    join
    check(q0, 8'hAA);
    check({7'h00, t1 > t0}, 8'h01);
    check({6'h00, sawBusy}, 8'h02);
    access(0, 1'b0, 11'h123, 8'h00, q0);
    check(q0, 8'h55);
    $display("t_contend_write done");
  endtask

  // Both ports read the same place at once.
  task automatic t_contend_read;
    logic [7:0] q0, q1;
    clrBusy = 1'b1;
    @(negedge sys_clk);
    clrBusy = 1'b0;
    fork
      access(0, 1'b0, 11'h123, 8'h00, q0);
      access(1, 1'b0, 11'h123, 8'h00, q1);
    join
    check(q0, 8'h55);
    check(q1, 8'h55);
    check({7'h00, ^sawBusy}, 8'h01);
    $display("t_contend_read done");
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    check({6'h00, chipSelN}, 8'h03);
    check({6'h00, writeN}, 8'h03);
    check({6'h00, outEnN}, 8'h03);
    check({reqReady, rspValid, portDataOe, irqPending}, 8'hC0);
    t_plain();
    t_mailbox();
    t_contend_write();
    t_contend_read();
    final_report();
  end
endmodule
